/* File: inc/frs_pkg.sv */
package frs_pkg;
  localparam int CLK_HZ       = 10_000_000;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_TIME_US;
  localparam int GATE_TIME_MS = 100;
  localparam int GATE_CYCLES  = CLK_HZ / 1000 * GATE_TIME_MS;
  localparam int GATE_PER_SEC = 1000 / GATE_TIME_MS;
  localparam int LOSS_UNIT_MS = 100;
  localparam int DW           = 20;
  localparam int TW           = 14;

  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_CUR_MINPT = 8'h04;
  localparam logic [7:0] ADDR_CUR_MINO  = 8'h08;
  localparam logic [7:0] ADDR_CUR_MAXPT = 8'h0C;
  localparam logic [7:0] ADDR_CUR_MAXO  = 8'h10;
  localparam logic [7:0] ADDR_CUR_FILT  = 8'h14;
  localparam logic [7:0] ADDR_PUL_FILT  = 8'h18;
  localparam logic [7:0] ADDR_PUL_MINPT = 8'h1C;
  localparam logic [7:0] ADDR_PUL_MINO  = 8'h20;
  localparam logic [7:0] ADDR_PUL_MAXPT = 8'h24;
  localparam logic [7:0] ADDR_PUL_MAXO  = 8'h28;
  localparam logic [7:0] ADDR_TIMEOUT   = 8'h2C;
  localparam logic [7:0] ADDR_VOLT_MIN  = 8'h30;
  localparam logic [7:0] ADDR_STATUS    = 8'h34;
  localparam logic [7:0] ADDR_REF_OUT   = 8'h38;
  localparam logic [7:0] ADDR_PUL_FREQ  = 8'h3C;

  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_PMETHOD = 3;
  localparam int CTRL_PROC    = 4;
  localparam int CTRL_EXTPROC = 5;
  localparam int CTRL_CRIT_LSB = 6;
  localparam int CTRL_ACT_LSB = 8;
  localparam int ST_ACTIVE    = 3;
  localparam int ST_UNIT      = 4;

  localparam logic [9:0]    CTRL_RST     = 10'h000;
  localparam logic [DW-1:0] CUR_MINPT_RST = 20'h00190;
  localparam logic [DW-1:0] CUR_MAXPT_RST = 20'h007D0;
  localparam logic [DW-1:0] CUR_LIM      = 20'h007D0;
  localparam logic [15:0]   OUT_MAX_RST  = 16'h1770;
  localparam logic [TW-1:0] FILT_RST     = 14'h000A;
  localparam logic [TW-1:0] FILT_LIM     = 14'h270F;
  localparam logic [DW-1:0] PUL_MIN_LIM  = 20'h02710;
  localparam logic [DW-1:0] PUL_MAXPT_RST = 20'h02710;
  localparam logic [DW-1:0] PUL_MAX_LIM  = 20'h186A0;
  localparam logic [15:0]   TIMEOUT_RST  = 16'h000A;
  localparam logic [15:0]   USER_MAX     = 16'h2710;

  typedef enum logic [2:0] {SRC_KEYPAD, SRC_VOLT, SRC_SVOLT, SRC_CURR, SRC_COMB, SRC_PULSE} frs_src_t;
  typedef enum logic [1:0] {CRIT_NONE, CRIT_HALF, CRIT_BELOW} frs_crit_t;
  typedef enum logic [1:0] {ACT_NONE, ACT_COAST, ACT_STOP} frs_act_t;
endpackage : frs_pkg

/* File: inc/frs_filt_if.sv */
interface frs_filt_if;
  import frs_pkg::*;
  logic [DW-1:0] sample;
  logic [TW-1:0] tau;
  logic          tick;
  logic [DW-1:0] filtered;
  modport src  (output sample, output tau, output tick, input filtered);
  modport filt (input sample, input tau, input tick, output filtered);
endinterface : frs_filt_if

/* File: src/frs_lpf.sv */
module frs_lpf (
  input wire logic clk_sys,
  input wire logic rst,
  frs_filt_if.filt f
);
  import frs_pkg::*;

  typedef struct packed {
    logic [DW+7:0] acc;
  } frs_lpf_st_t;

  frs_lpf_st_t st;
  frs_lpf_st_t next_st;
  logic signed [DW+8:0] diff;
  logic signed [DW+8:0] step;
  logic signed [DW+8:0] sum;

  // First order: per ms, move 1/tau of the gap
  always_comb begin
    next_st = st;
    diff = $signed({1'b0, f.sample, 8'h00}) - $signed({1'b0, st.acc});
    step = diff / $signed({1'b0, f.tau});
    sum = $signed({1'b0, st.acc}) + step;
    if (f.tick) begin
      if (f.tau == '0) begin
        next_st.acc = {f.sample, 8'h00};
      end else begin
        next_st.acc = sum[DW+7:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign f.filtered = st.acc[DW+7:8];

  a_lpf_bypass: assert property (@(posedge clk_sys) disable iff (rst)
    f.tick && f.tau == '0 |=> f.filtered == $past(f.sample))
    else $error("filter bypass failed");
  a_lpf_bounded: assert property (@(posedge clk_sys) disable iff (rst)
    f.tick && f.tau > 14'h0001 && f.sample > f.filtered |=> f.filtered <= $past(f.sample))
    else $error("filter overshoot");
endmodule : frs_lpf

/* File: src/frs_scaler.sv */
// Functional notes
// - Current scaling used only for current-alone or combined source
// - Current at minimum point yields minimum output; point 0-20 mA, default 4
// - Current at maximum point yields maximum output; defaults 20 mA, 60 Hz
// - Current input filtered, time constant default 10 ms
// - Pulse terminals drive the command only with pulse source
// - Pulse method: first terminal alone (default) or both terminals
// - Pulse frequency filtered, constant 0-9999 ms, default 10 ms
// - Minimum pulse point 0-10 kHz maps to minimum output, both default 0
// - Maximum pulse point 10-100 kHz, default 10 kHz, maps to maximum output
// - Each pulse terminal accepts up to 100 kHz
// - With a process loop enabled, outputs are user-unit targets 0 to 100.00
// - Loss detection in voltage, signed, current, combined, pulse; combined ignores current
// - Half criterion: lost below half the minimum point; none disables
// - Below criterion: lost below the minimum point
// - After loss: keep running, coast at once, or decelerate
// - Loss declared only after condition persists for the timeout, default 1.0 s
// - Separate loss indication for voltage, current and pulse references
//
// The strobed register port and the address map were decided locally.
module frs_scaler #(
  parameter int TICK_COUNT = frs_pkg::TICK_CYCLES,
  parameter int GATE_COUNT = frs_pkg::GATE_CYCLES
) (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic [7:0]         regAddr,
  input  wire logic [31:0]        regWdata,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output logic      [31:0]        regRdata,
  input  wire logic [15:0]        currentSample,
  input  wire logic signed [15:0] voltageSample,
  input  wire logic               pulseFirst,
  input  wire logic               pulseSecond,
  output logic      [15:0]        refOut,
  output logic                    refValid,
  output logic                    unitMode,
  output logic                    voltLost,
  output logic                    currLost,
  output logic                    pulseLost,
  output logic                    coastOnLoss,
  output logic                    decelOnLoss
);
  import frs_pkg::*;

  if (TICK_COUNT < 2 || TICK_COUNT >= 2**24) begin : g_chk_tick
    $error("TICK_COUNT out of range");
  end
  if (GATE_COUNT < 2 || GATE_COUNT >= 2**24) begin : g_chk_gate
    $error("GATE_COUNT out of range");
  end

  typedef struct packed {
    logic [9:0]    ctrl;
    logic [DW-1:0] curMinPt;
    logic [15:0]   curMinOut;
    logic [DW-1:0] curMaxPt;
    logic [15:0]   curMaxOut;
    logic [TW-1:0] curTau;
    logic [TW-1:0] pulTau;
    logic [DW-1:0] pulMinPt;
    logic [15:0]   pulMinOut;
    logic [DW-1:0] pulMaxPt;
    logic [15:0]   pulMaxOut;
    logic [15:0]   timeout;
    logic [15:0]   voltMinPt;
    logic [2:0]    syncA;
    logic [2:0]    syncB;
    logic [23:0]   tickCnt;
    logic          tick;
    logic [23:0]   gateCnt;
    logic [DW-1:0] edgeCnt;
    logic [DW-1:0] pulFreq;
    logic [23:0]   lossCnt;
    logic [2:0]    lossLevel;
    logic [2:0]    lossSticky;
    logic [15:0]   refOut;
    logic          refValid;
    logic [31:0]   rdata;
  } frs_st_t;

  frs_st_t st;
  frs_st_t next_st;

  frs_filt_if curF ();
  frs_filt_if pulF ();

  frs_lpf u_cur_lpf (.clk_sys(clk_sys), .rst(rst), .f(curF.filt));
  frs_lpf u_pul_lpf (.clk_sys(clk_sys), .rst(rst), .f(pulF.filt));

  assign curF.sample = {4'h0, currentSample};
  assign curF.tau    = st.curTau;
  assign curF.tick   = st.tick;
  assign pulF.sample = st.pulFreq;
  assign pulF.tau    = st.pulTau;
  assign pulF.tick   = st.tick;

  function automatic logic [DW-1:0] frs_sat(input logic [DW-1:0] v, input logic [DW-1:0] lo,
                                            input logic [DW-1:0] hi);
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction : frs_sat

  function automatic logic [15:0] frs_map(input logic [DW-1:0] x, input logic [DW-1:0] x1,
                                          input logic [DW-1:0] x2, input logic [15:0] y1,
                                          input logic [15:0] y2);
    logic signed [DW:0] dx;
    logic signed [DW:0] span;
    logic signed [16:0] dy;
    logic signed [38:0] prod;
    logic signed [38:0] q;
    logic signed [17:0] r;
    if (x <= x1 || x2 <= x1) return y1;
    if (x >= x2) return y2;
    dx = $signed({1'b0, x}) - $signed({1'b0, x1});
    span = $signed({1'b0, x2}) - $signed({1'b0, x1});
    dy = $signed({1'b0, y2}) - $signed({1'b0, y1});
    prod = dx * dy;
    q = prod / span;
    r = $signed({2'b00, y1}) + q[17:0];
    return r[15:0];
  endfunction : frs_map

  frs_src_t      src;
  frs_crit_t     crit;
  frs_act_t      act;
  logic          procMode;
  logic          useCur;
  logic          usePul;
  logic          edgeA;
  logic          edgeB;
  logic [1:0]    edges;
  logic [15:0]   mapped;
  logic [DW-1:0] lx;
  logic [DW-1:0] lmin;
  logic [2:0]    lossSel;
  logic          lossCond;
  logic [23:0]   lossLimit;

  always_comb begin
    next_st = st;
    src = frs_src_t'(st.ctrl[CTRL_SRC_LSB +: 3]);
    crit = frs_crit_t'(st.ctrl[CTRL_CRIT_LSB +: 2]);
    act = frs_act_t'(st.ctrl[CTRL_ACT_LSB +: 2]);
    procMode = st.ctrl[CTRL_PROC] | st.ctrl[CTRL_EXTPROC];
    useCur = (src == SRC_CURR) || (src == SRC_COMB);
    usePul = (src == SRC_PULSE);

    // Pins are slow against 10 MHz, so 100 kHz edges are never missed
    next_st.syncA = {st.syncA[1:0], pulseFirst};
    next_st.syncB = {st.syncB[1:0], pulseSecond};
    edgeA = st.syncA[1] & ~st.syncA[2];
    edgeB = st.syncB[1] & ~st.syncB[2] & st.ctrl[CTRL_PMETHOD];
    edges = {1'b0, edgeA} + {1'b0, edgeB};

    next_st.tick = 1'b0;
    next_st.tickCnt = st.tickCnt + 24'h000001;
    if (st.tickCnt == 24'(TICK_COUNT - 1)) begin
      next_st.tickCnt = '0;
      next_st.tick = 1'b1;
    end

    // Gate window counts edges, then scales to Hz
    next_st.edgeCnt = st.edgeCnt + DW'(edges);
    next_st.gateCnt = st.gateCnt + 24'h000001;
    if (st.gateCnt == 24'(GATE_COUNT - 1)) begin
      next_st.gateCnt = '0;
      next_st.edgeCnt = DW'(edges);
      next_st.pulFreq = DW'(st.edgeCnt * GATE_PER_SEC);
    end

    if (useCur) begin
      mapped = frs_map(curF.filtered, st.curMinPt, st.curMaxPt, st.curMinOut, st.curMaxOut);
    end else begin
      mapped = frs_map(pulF.filtered, st.pulMinPt, st.pulMaxPt, st.pulMinOut, st.pulMaxOut);
    end
    if (procMode && mapped > USER_MAX) begin
      mapped = USER_MAX;
    end
    next_st.refValid = useCur | usePul;
    next_st.refOut = (useCur | usePul) ? mapped : 16'h0000;

    lx = '0;
    lmin = '0;
    lossSel = 3'b000;
    unique case (src)
      SRC_VOLT, SRC_SVOLT, SRC_COMB: begin
        // Combined mode watches only the voltage reference
        lx = {4'h0, voltageSample[15] ? 16'(-voltageSample) : voltageSample};
        lmin = {4'h0, st.voltMinPt};
        lossSel = 3'b001;
      end
      SRC_CURR: begin
        lx = curF.filtered;
        lmin = st.curMinPt;
        lossSel = 3'b010;
      end
      SRC_PULSE: begin
        lx = pulF.filtered;
        lmin = st.pulMinPt;
        lossSel = 3'b100;
      end
      SRC_KEYPAD: lossSel = 3'b000;
      default:    lossSel = 3'b000;
    endcase
    unique case (crit)
      CRIT_HALF:  lossCond = lx < (lmin >> 1);
      CRIT_BELOW: lossCond = lx < lmin;
      CRIT_NONE:  lossCond = 1'b0;
      default:    lossCond = 1'b0;
    endcase
    lossCond = lossCond && (lossSel != 3'b000);

    lossLimit = 24'(st.timeout * LOSS_UNIT_MS);
    if (!lossCond) begin
      next_st.lossCnt = '0;
    end else if (st.tick && st.lossCnt < lossLimit) begin
      next_st.lossCnt = st.lossCnt + 24'h000001;
    end
    next_st.lossLevel = (lossCond && st.lossCnt >= lossLimit) ? lossSel : 3'b000;

    next_st.rdata = '0;
    if (regWr) begin
      unique case (regAddr)
        ADDR_CTRL:      next_st.ctrl = regWdata[9:0];
        ADDR_CUR_MINPT: next_st.curMinPt = frs_sat(regWdata[DW-1:0], '0, CUR_LIM);
        ADDR_CUR_MINO:  next_st.curMinOut = regWdata[15:0];
        ADDR_CUR_MAXPT: next_st.curMaxPt = frs_sat(regWdata[DW-1:0], '0, CUR_LIM);
        ADDR_CUR_MAXO:  next_st.curMaxOut = regWdata[15:0];
        ADDR_CUR_FILT:  next_st.curTau = TW'(frs_sat(regWdata[DW-1:0], '0, DW'(FILT_LIM)));
        ADDR_PUL_FILT:  next_st.pulTau = TW'(frs_sat(regWdata[DW-1:0], '0, DW'(FILT_LIM)));
        ADDR_PUL_MINPT: next_st.pulMinPt = frs_sat(regWdata[DW-1:0], '0, PUL_MIN_LIM);
        ADDR_PUL_MINO:  next_st.pulMinOut = regWdata[15:0];
        ADDR_PUL_MAXPT: next_st.pulMaxPt = frs_sat(regWdata[DW-1:0], PUL_MIN_LIM, PUL_MAX_LIM);
        ADDR_PUL_MAXO:  next_st.pulMaxOut = regWdata[15:0];
        ADDR_TIMEOUT:   next_st.timeout = regWdata[15:0];
        ADDR_VOLT_MIN:  next_st.voltMinPt = regWdata[15:0];
        ADDR_STATUS:    next_st.lossSticky = st.lossSticky & ~regWdata[2:0];
        default:        next_st.rdata = '0;
      endcase
    end
    // New loss wins over a clear in the same cycle
    next_st.lossSticky = next_st.lossSticky | st.lossLevel;
    if (regRd) begin
      unique case (regAddr)
        ADDR_CTRL:      next_st.rdata = {22'h0, st.ctrl};
        ADDR_CUR_MINPT: next_st.rdata = {12'h0, st.curMinPt};
        ADDR_CUR_MINO:  next_st.rdata = {16'h0, st.curMinOut};
        ADDR_CUR_MAXPT: next_st.rdata = {12'h0, st.curMaxPt};
        ADDR_CUR_MAXO:  next_st.rdata = {16'h0, st.curMaxOut};
        ADDR_CUR_FILT:  next_st.rdata = {18'h0, st.curTau};
        ADDR_PUL_FILT:  next_st.rdata = {18'h0, st.pulTau};
        ADDR_PUL_MINPT: next_st.rdata = {12'h0, st.pulMinPt};
        ADDR_PUL_MINO:  next_st.rdata = {16'h0, st.pulMinOut};
        ADDR_PUL_MAXPT: next_st.rdata = {12'h0, st.pulMaxPt};
        ADDR_PUL_MAXO:  next_st.rdata = {16'h0, st.pulMaxOut};
        ADDR_TIMEOUT:   next_st.rdata = {16'h0, st.timeout};
        ADDR_VOLT_MIN:  next_st.rdata = {16'h0, st.voltMinPt};
        ADDR_STATUS:    next_st.rdata = {27'h0, procMode, |st.lossLevel, st.lossSticky};
        ADDR_REF_OUT:   next_st.rdata = {15'h0, st.refValid, st.refOut};
        ADDR_PUL_FREQ:  next_st.rdata = {12'h0, st.pulFreq};
        default:        next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
      st.ctrl <= CTRL_RST;
      // Idle pins sit high; avoids a false edge after reset
      st.syncA <= 3'b111;
      st.syncB <= 3'b111;
      st.curMinPt <= CUR_MINPT_RST;
      st.curMaxPt <= CUR_MAXPT_RST;
      st.curMaxOut <= OUT_MAX_RST;
      st.curTau <= FILT_RST;
      st.pulTau <= FILT_RST;
      st.pulMaxPt <= PUL_MAXPT_RST;
      st.pulMaxOut <= OUT_MAX_RST;
      st.timeout <= TIMEOUT_RST;
    end else begin
      st <= next_st;
    end
  end

  assign regRdata = st.rdata;
  assign refOut = st.refOut;
  assign refValid = st.refValid;
  assign unitMode = st.ctrl[CTRL_PROC] | st.ctrl[CTRL_EXTPROC];
  assign voltLost = st.lossLevel[0];
  assign currLost = st.lossLevel[1];
  assign pulseLost = st.lossLevel[2];
  // Drive output removed at once, or ramp down on its decel time
  assign coastOnLoss = (|st.lossLevel) && act == ACT_COAST;
  assign decelOnLoss = (|st.lossLevel) && act == ACT_STOP;

  sequence s_cur_at_min;
    useCur && curF.filtered == st.curMinPt && st.curMaxPt > st.curMinPt && !procMode;
  endsequence
  sequence s_cur_at_max;
    useCur && curF.filtered == st.curMaxPt && st.curMaxPt > st.curMinPt && !procMode;
  endsequence
  sequence s_lost_steady;
    lossCond && lossSel == $past(lossSel) && st.lossCnt >= lossLimit;
  endsequence

  a_ref_source: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 refValid == $past(useCur || usePul))
    else $error("reference valid does not match source");
  a_cur_min_out: assert property (@(posedge clk_sys) disable iff (rst)
    s_cur_at_min |=> refOut == $past(st.curMinOut))
    else $error("minimum current point not mapped");
  a_cur_max_out: assert property (@(posedge clk_sys) disable iff (rst)
    s_cur_at_max |=> refOut == $past(st.curMaxOut))
    else $error("maximum current point not mapped");
  a_pulse_max_out: assert property (@(posedge clk_sys) disable iff (rst)
    usePul && pulF.filtered >= st.pulMaxPt && st.pulMaxPt > st.pulMinPt && !procMode
    |=> refOut == $past(st.pulMaxOut))
    else $error("maximum pulse point not clamped");
  a_pulse_min_out: assert property (@(posedge clk_sys) disable iff (rst)
    usePul && pulF.filtered <= st.pulMinPt && !procMode |=> refOut == $past(st.pulMinOut))
    else $error("minimum pulse point not clamped");
  a_user_unit_cap: assert property (@(posedge clk_sys) disable iff (rst)
    procMode && $stable(procMode) |-> st.refOut <= USER_MAX)
    else $error("user-unit target above 100.00");
  a_crit_none: assert property (@(posedge clk_sys) disable iff (rst)
    crit == CRIT_NONE [*2] |-> st.lossLevel == 3'b000)
    else $error("loss declared with detection off");
  a_loss_timeout: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(|st.lossLevel) |-> $past(st.lossCnt) >= $past(lossLimit) && $past(lossCond))
    else $error("loss declared before timeout");
  a_loss_declared: assert property (@(posedge clk_sys) disable iff (rst)
    s_lost_steady |=> st.lossLevel == $past(lossSel))
    else $error("loss indication wrong or missing");
  a_comb_no_curr: assert property (@(posedge clk_sys) disable iff (rst)
    src == SRC_COMB |=> !currLost)
    else $error("current loss flagged in combined mode");
  a_coast_now: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(|st.lossLevel) && act == ACT_COAST |-> coastOnLoss && !decelOnLoss)
    else $error("coast not applied on loss");
endmodule : frs_scaler

/* File: verif/frs_pulse_source.sv */
module frs_pulse_source (
  input  wire logic       clk_sys,
  input  wire logic [7:0] periodFirst,
  input  wire logic [7:0] periodSecond,
  output logic            pulseFirst,
  output logic            pulseSecond
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cntFirst  = 8'h00;
  logic [7:0] cntSecond = 8'h00;

  initial begin
    pulseFirst = 1'b1;
    pulseSecond = 1'b1;
  end

  // Period zero: open collector off, pull-up holds the line high
  always @(posedge clk_sys) begin
    cntFirst <= (cntFirst + 8'h01 >= periodFirst) ? 8'h00 : cntFirst + 8'h01;
    cntSecond <= (cntSecond + 8'h01 >= periodSecond) ? 8'h00 : cntSecond + 8'h01;
    pulseFirst <= (periodFirst == 8'h00) || (cntFirst >= periodFirst / 2);
    pulseSecond <= (periodSecond == 8'h00) || (cntSecond >= periodSecond / 2);
  end
endmodule : frs_pulse_source

/* File: verif/test_freq_reference_input_scaler.sv */
module test_freq_reference_input_scaler;
  import frs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk_sys       = 1'b0;
  logic               rst           = 1'b1;
  logic [7:0]         regAddr       = 8'h00;
  logic [31:0]        regWdata      = 32'h0;
  logic               regWr         = 1'b0;
  logic               regRd         = 1'b0;
  logic [31:0]        regRdata;
  logic [15:0]        currentSample = 16'h0;
  logic signed [15:0] voltageSample = 16'sh0;
  logic               pulseFirst;
  logic               pulseSecond;
  logic [15:0]        refOut;
  logic               refValid;
  logic               unitMode;
  logic               voltLost;
  logic               currLost;
  logic               pulseLost;
  logic               coastOnLoss;
  logic               decelOnLoss;
  logic [7:0]         perA          = 8'h00;
  logic [7:0]         perB          = 8'h00;
  logic [31:0]        expQ[$];
  logic               rdSeen        = 1'b0;
  logic [31:0]        rng           = 32'hC823;
  logic [15:0]        k;
  int                 n;
  int                 n_fail        = 0;
  int                 check_count   = 0;
  logic [7:0]  dA[12] = '{ADDR_CTRL, ADDR_CUR_MINPT, ADDR_CUR_MINO, ADDR_CUR_MAXPT, ADDR_CUR_MAXO,
    ADDR_CUR_FILT, ADDR_PUL_FILT, ADDR_PUL_MINPT, ADDR_PUL_MAXPT, ADDR_PUL_MAXO, ADDR_TIMEOUT, 8'hFC};
  logic [31:0] dE[12] = '{32'h0, 32'h190, 32'h0, 32'h7D0, 32'h1770, 32'hA, 32'hA, 32'h0, 32'h2710,
    32'h1770, 32'hA, 32'h0};

  always #50 clk_sys = ~clk_sys;

  frs_scaler #(.TICK_COUNT(10), .GATE_COUNT(1000)) uut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .currentSample(currentSample),
    .voltageSample(voltageSample), .pulseFirst(pulseFirst), .pulseSecond(pulseSecond), .refOut(refOut),
    .refValid(refValid), .unitMode(unitMode), .voltLost(voltLost), .currLost(currLost),
    .pulseLost(pulseLost), .coastOnLoss(coastOnLoss), .decelOnLoss(decelOnLoss));
  frs_pulse_source far (.clk_sys(clk_sys), .periodFirst(perA), .periodSecond(perB),
    .pulseFirst(pulseFirst), .pulseSecond(pulseSecond));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
      n_fail++;
    end
  endtask : chk

  task automatic cmp_flags(string nm, logic [6:0] e);
    chk(nm, {25'h0, e}, {25'h0, voltLost, currLost, pulseLost, coastOnLoss, decelOnLoss, unitMode, refValid});
  endtask : cmp_flags

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rdSeen && expQ.size() > 0) begin
      chk("regRdata", expQ.pop_front(), regRdata);
    end
    rdSeen <= regRd;
  end

  task automatic cyc(int c);
    repeat (c) @(posedge clk_sys);
  endtask : cyc

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [31:0] e);
    expQ.push_back(e);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
  endtask : rd

  task automatic done(string s);
    $display("test %s done", s);
  endtask : done

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  task automatic mapc(logic [15:0] c, logic [15:0] e);
    @(posedge clk_sys);
    currentSample <= c;
    cyc(40);
    rd(ADDR_REF_OUT, {15'h0, 1'b1, e});
  endtask : mapc

  task automatic lcase(logic [9:0] ct, logic [15:0] c, logic signed [15:0] v, logic [7:0] p, logic [6:0] e);
    @(posedge clk_sys);
    currentSample <= c;
    voltageSample <= v;
    perA <= p;
    wr(ADDR_CTRL, {22'h0, ct});
    cyc(400);
    cmp_flags("lossFlags", e);
  endtask : lcase

  initial begin
    cyc(8);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) rd(dA[i], dE[i]);
    done("defaults");
    wr(ADDR_PUL_FILT, 32'hFFFF);
    rd(ADDR_PUL_FILT, 32'h270F);
    wr(ADDR_PUL_MINPT, 32'h4E20);
    rd(ADDR_PUL_MINPT, 32'h2710);
    wr(ADDR_PUL_MAXPT, 32'h30D40);
    rd(ADDR_PUL_MAXPT, 32'h186A0);
    wr(ADDR_CUR_MINPT, 32'hBB8);
    rd(ADDR_CUR_MINPT, 32'h7D0);
    wr(ADDR_PUL_MINPT, 32'h0);
    wr(ADDR_PUL_MAXPT, 32'h2710);
    wr(ADDR_CUR_MINPT, 32'h190);
    wr(ADDR_PUL_FILT, 32'h0);
    wr(ADDR_CUR_FILT, 32'h0);
    done("saturate");
    currentSample <= 16'h7D0;
    wr(ADDR_CTRL, 32'h1);
    cyc(40);
    cmp_flags("voltSource", 7'h00);
    wr(ADDR_CTRL, 32'h3);
    mapc(16'h190, 16'h0);
    mapc(16'h7D0, 16'h1770);
    mapc(16'h64, 16'h0);
    mapc(16'h834, 16'h1770);
    for (int i = 0; i < 4; i++) begin
      k = 16'(xs() % 32'h65);
      mapc(16'h190 + k * 16'h10, k * 16'h3C);
    end
    done("mapping");
    mapc(16'h190, 16'h0);
    wr(ADDR_CUR_FILT, 32'hA);
    currentSample <= 16'h7D0;
    cyc(25);
    chk("filterLag", 32'h1, {31'h0, refOut > 16'h0 && refOut < 16'h1770});
    cyc(2000);
    chk("filterSettle", 32'h1, {31'h0, refOut >= 16'h1760 && refOut <= 16'h1770});
    wr(ADDR_CUR_FILT, 32'h0);
    done("filter");
    wr(ADDR_CUR_MAXO, 32'h4E20);
    wr(ADDR_CTRL, 32'h13);
    cyc(40);
    rd(ADDR_REF_OUT, 32'h12710);
    cmp_flags("procLoop", 7'h03);
    wr(ADDR_CTRL, 32'h23);
    cyc(5);
    cmp_flags("extProcLoop", 7'h03);
    wr(ADDR_CUR_MAXO, 32'h1770);
    wr(ADDR_CTRL, 32'h3);
    done("unit");
    currentSample <= 16'h190;
    perA <= 8'h04;
    cyc(500);
    rd(ADDR_REF_OUT, 32'h10000);
    wr(ADDR_CTRL, 32'h5);
    cyc(2100);
    rd(ADDR_PUL_FREQ, 32'h9C4);
    rd(ADDR_REF_OUT, 32'h105DC);
    wr(ADDR_CTRL, 32'hD);
    perB <= 8'h04;
    cyc(2100);
    rd(ADDR_PUL_FREQ, 32'h1388);
    rd(ADDR_REF_OUT, 32'h10BB8);
    perA <= 8'h02;
    perB <= 8'h02;
    cyc(2100);
    rd(ADDR_PUL_FREQ, 32'h2710);
    rd(ADDR_REF_OUT, 32'h11770);
    perB <= 8'h00;
    done("pulse");
    wr(ADDR_TIMEOUT, 32'h0);
    wr(ADDR_VOLT_MIN, 32'h1F4);
    wr(ADDR_PUL_MINPT, 32'hFA0);
    lcase(10'h183, 16'h12C, 16'sh0, 8'h00, 7'h29);
    lcase(10'h243, 16'h12C, 16'sh0, 8'h00, 7'h01);
    lcase(10'h243, 16'h96, 16'sh0, 8'h00, 7'h25);
    lcase(10'h103, 16'h0, 16'sh0, 8'h00, 7'h01);
    lcase(10'h184, 16'h0, 16'sh320, 8'h00, 7'h01);
    lcase(10'h184, 16'h0, 16'sh12C, 8'h00, 7'h49);
    lcase(10'h082, 16'h0, -16'sh12C, 8'h00, 7'h40);
    lcase(10'h285, 16'h0, 16'sh0, 8'h04, 7'h15);
    rd(ADDR_STATUS, 32'hF);
    wr(ADDR_STATUS, 32'h7);
    rd(ADDR_STATUS, 32'hC);
    lcase(10'h281, 16'h0, 16'sh320, 8'h00, 7'h00);
    lcase(10'h180, 16'h0, 16'sh0, 8'h00, 7'h00);
    done("loss");
    wr(ADDR_TIMEOUT, 32'h1);
    lcase(10'h183, 16'h7D0, 16'sh0, 8'h00, 7'h01);
    currentSample <= 16'h12C;
    n = 0;
    while (currLost !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    chk("lossDelay", 32'h1, {31'h0, n >= 990 && n <= 1040});
    // A spent wait is already a mismatch; skip straight to the report
    if (n < 3000) begin
      currentSample <= 16'h7D0;
      cyc(40);
      cmp_flags("lossClear", 7'h01);
      done("timeout");
    end
    cyc(4);
    chk("readQueue", 32'h0, expQ.size());
    stop_test();
  end
endmodule : test_freq_reference_input_scaler
